/* afwcr_defs.svh */
// timing, width and position constants shared by both ends of the converter link
`ifndef AFWCR_DEFS_SVH
`define AFWCR_DEFS_SVH

`define AFW_CLK_NS       5
`define AFW_CONV_NS      290
`define AFW_CONV_MAX_NS  320
`define AFW_CONV_CYC     ((`AFW_CONV_NS + `AFW_CLK_NS - 1) / `AFW_CLK_NS)
`define AFW_CONV_MAX_CYC ((`AFW_CONV_MAX_NS + `AFW_CLK_NS - 1) / `AFW_CLK_NS)
`define AFW_HALF_SCK     4
`define AFW_SETUP_CYC    2
`define AFW_DATA_BITS    18
`define AFW_STAT_BITS    6
`define AFW_FULL_BITS    24
`define AFW_WORD_MSB     24
`define AFW_CMD_BITS     16
`define AFW_PASS_TAP     7

`endif

/* afwcr_pkg.sv */
// types shared by the converter end and the host end
package afwcr_pkg;
  typedef enum logic [1:0] {
    MODE_CS_FREE = 2'b00,
    MODE_CS_BUSY = 2'b01,
    MODE_CHAIN   = 2'b10
  } afwcr_mode_t;

  typedef enum logic [1:0] {
    DEV_ACQ  = 2'b00,
    DEV_CONV = 2'b01,
    DEV_READ = 2'b10
  } afwcr_dev_st_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_CONV  = 3'b010,
    H_WAIT  = 3'b011,
    H_SHIFT = 3'b100,
    H_DONE  = 3'b101,
    H_WRITE = 3'b110
  } afwcr_host_st_t;
endpackage

/* afwcr_if.sv */
// serial link between host and converter, with pulled-up data line
interface afwcr_if;
  logic sck;
  logic convStart;
  logic sdi;
  logic sdoOut;
  logic sdoOe;
  wire  sdoLine;

  // pull-up resolves the released line high
  assign sdoLine = sdoOe ? sdoOut : 1'b1;

  modport dev (
    input  sck,
    input  convStart,
    input  sdi,
    output sdoOut,
    output sdoOe
  );

  modport host (
    output sck,
    output convStart,
    output sdi,
    input  sdoLine
  );
endinterface

/* afwcr_device.sv */
// converter end: conversion timing, chip-select and chain readout, chain writes
`include "afwcr_defs.svh"
module afwcr_device (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [17:0] sampleData,
  input  wire logic [5:0]  statusBits,
  input  wire logic        statusOn,
  output logic             convDone,
  output logic             regValid,
  output logic [7:0]       regCmd,
  output logic [7:0]       regData,
  output logic             chainMode,
  afwcr_if.dev             lnk
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] toGray(input logic [15:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [15:0] fromGray(input logic [15:0] g);
    logic [15:0] b;
    b = g;
    for (int i = 14; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // bit shown after idx falls: result word first, then upstream data
  function automatic logic pickBit(input logic [15:0] idx,
                                   input logic [24:0] word,
                                   input logic [4:0]  len,
                                   input logic [23:0] hist);
    logic [4:0] pos;
    logic [4:0] tap;
    pos = 5'(`AFW_WORD_MSB) - idx[4:0];
    tap = len - 5'h01;
    if (idx < {11'h000, len}) begin
      return word[pos];
    end
    return hist[tap];
  endfunction

  // ------------------------------------------------------------
  // core-domain state
  // ------------------------------------------------------------
  afwcr_pkg::afwcr_dev_st_t state;
  afwcr_pkg::afwcr_mode_t   mode;
  logic [9:0]  convCnt;
  logic [24:0] resultWord;
  logic [4:0]  streamLen;
  logic [15:0] base;
  logic [15:0] wrBase;
  logic        ended;

  // synchronisers and edge history
  logic        cnvMeta, cnvSync, cnvPrev;
  logic        sdiMeta, sdiSync, sdiPrev;
  logic        sckMeta, sckSync;
  logic [15:0] grayMeta, graySync;

  // ------------------------------------------------------------
  // link domain: runs on sck only while the host clocks a frame
  // ------------------------------------------------------------
  logic [23:0] ins;
  logic [15:0] edgeCnt;
  logic [15:0] edgeGray;
  logic        sdoBit;
  logic        passBit;

  // upstream data enters on every rising edge
  always_ff @(posedge lnk.sck or negedge resetn) begin
    if (!resetn) begin
      ins <= 24'h00_0000;
    end else begin
      ins <= {ins[22:0], lnk.sdi};
    end
  end

  wire logic [15:0] nextEdge = edgeCnt + 16'h0001;
  wire logic [15:0] nextIdx  = nextEdge - base;

  // each falling edge presents the next bit
  always_ff @(negedge lnk.sck or negedge resetn) begin
    if (!resetn) begin
      edgeCnt  <= 16'h0000;
      edgeGray <= 16'h0000;
      sdoBit   <= 1'b0;
      passBit  <= 1'b0;
    end else begin
      edgeCnt  <= nextEdge;
      edgeGray <= toGray(nextEdge);
      sdoBit   <= pickBit(nextIdx, resultWord, streamLen, ins);
      passBit  <= ins[`AFW_PASS_TAP];
    end
  end

  // ------------------------------------------------------------
  // crossings into the core domain
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnvMeta  <= 1'b0;
      cnvSync  <= 1'b0;
      cnvPrev  <= 1'b0;
      sdiMeta  <= 1'b1;
      sdiSync  <= 1'b1;
      sdiPrev  <= 1'b1;
      sckMeta  <= 1'b0;
      sckSync  <= 1'b0;
      grayMeta <= 16'h0000;
      graySync <= 16'h0000;
    end else begin
      cnvMeta  <= lnk.convStart;
      cnvSync  <= cnvMeta;
      cnvPrev  <= cnvSync;
      sdiMeta  <= lnk.sdi;
      sdiSync  <= sdiMeta;
      sdiPrev  <= sdiSync;
      sckMeta  <= lnk.sck;
      sckSync  <= sckMeta;
      grayMeta <= edgeGray;
      graySync <= grayMeta;
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic        cnvRise  = cnvSync & ~cnvPrev;
  wire logic        cnvFall  = ~cnvSync & cnvPrev;
  wire logic        sdiRise  = sdiSync & ~sdiPrev;
  wire logic [15:0] edgeSeen = fromGray(graySync);
  wire logic [15:0] writeLen = edgeSeen - wrBase;
  wire logic        isChain  = (mode == afwcr_pkg::MODE_CHAIN);
  // sdi high at the rise picks chip-select; sdi and sck both low pick the chain
  wire logic        csPick   = sdiSync | sckSync;
  wire logic        convEnd  = (state == afwcr_pkg::DEV_CONV)
                               && (convCnt == 10'(`AFW_CONV_CYC - 1));
  wire logic        busyNow  = ~isChain & ~sdiSync;
  wire logic        writeOk  = isChain && (writeLen >= 16'(`AFW_CMD_BITS));
  wire logic [4:0]  dataLen  = statusOn ? 5'(`AFW_FULL_BITS) : 5'(`AFW_DATA_BITS);

  // result word, msb aligned; busy mode leads with a low bit
  wire logic [24:0] nextWord = busyNow ? {1'b0, sampleData, statusBits}
                                       : {sampleData, statusBits, 1'b0};

  // ------------------------------------------------------------
  // conversion and readout sequencing
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state      <= afwcr_pkg::DEV_ACQ;
      mode       <= afwcr_pkg::MODE_CS_FREE;
      convCnt    <= 10'h000;
      resultWord <= 25'h000_0000;
      streamLen  <= 5'h12;
      base       <= 16'h0000;
      wrBase     <= 16'h0000;
      ended      <= 1'b0;
      convDone   <= 1'b0;
      regValid   <= 1'b0;
      regCmd     <= 8'h00;
      regData    <= 8'h00;
    end else begin
      convDone <= 1'b0;
      regValid <= 1'b0;
      unique case (state)
        afwcr_pkg::DEV_ACQ: begin
          if (cnvRise) begin
            state   <= afwcr_pkg::DEV_CONV;
            convCnt <= 10'h000;
            ended   <= 1'b0;
            mode    <= csPick ? afwcr_pkg::MODE_CS_FREE
                              : afwcr_pkg::MODE_CHAIN;
            if (writeOk) begin
              regValid <= 1'b1;
              regCmd   <= ins[15:8];
              regData  <= ins[7:0];
            end
          end else if (cnvFall) begin
            wrBase <= edgeSeen;
          end
        end
        afwcr_pkg::DEV_CONV: begin
          convCnt <= convCnt + 10'h001;
          if (convEnd) begin
            state      <= afwcr_pkg::DEV_READ;
            convDone   <= 1'b1;
            base       <= edgeSeen;
            resultWord <= nextWord;
            streamLen  <= dataLen + {4'h0, busyNow};
            if (busyNow) begin
              mode <= afwcr_pkg::MODE_CS_BUSY;
            end
          end
        end
        afwcr_pkg::DEV_READ: begin
          if (sdiRise && !isChain) begin
            ended <= 1'b1;
          end
          if (cnvFall) begin
            state  <= afwcr_pkg::DEV_ACQ;
            wrBase <= edgeSeen;
          end
        end
        default: begin
          state <= afwcr_pkg::DEV_ACQ;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // sdo drive
  // ------------------------------------------------------------
  // counts of falls since readout began; base stays still while sck runs
  wire logic [15:0] readLen = edgeCnt - base;
  wire logic        anyFall = (edgeCnt != base);
  wire logic        doneRd  = (readLen >= {11'h000, streamLen});
  wire logic        inRead  = (state == afwcr_pkg::DEV_READ);
  wire logic        busyMd  = (mode == afwcr_pkg::MODE_CS_BUSY);

  // chip-select readout: busy mode drives at once, else when sdi low
  wire logic csDrive    = inRead & ~isChain & ~ended & ~doneRd
                          & (busyMd | ~sdiSync);
  wire logic chainDrive = inRead & isChain & cnvSync;
  wire logic writeAct   = (state == afwcr_pkg::DEV_ACQ) & isChain & ~cnvSync
                          & (writeLen != 16'h0000);
  wire logic lowDrive   = ~cnvSync & ~sdiSync;
  wire logic dataDrive  = csDrive | chainDrive;

  assign lnk.sdoOe  = dataDrive | writeAct | lowDrive;
  assign lnk.sdoOut = dataDrive ? (anyFall ? sdoBit : resultWord[`AFW_WORD_MSB])
                    : writeAct ? passBit : 1'b0;
  assign chainMode  = isChain;

endmodule // afwcr_device

/* afwcr_host.sv */
// host end: drives convert_start, sdi and sck, collects result words
`include "afwcr_defs.svh"
module afwcr_host (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   startReq,
  input  wire afwcr_pkg::afwcr_mode_t modeReq,
  input  wire logic                   statusOn,
  input  wire logic [3:0]             chainCount,
  input  wire logic                   writeReq,
  input  wire logic [7:0]             wrCmd,
  input  wire logic [7:0]             wrData,
  input  wire logic [8:0]             wrClocks,
  output logic                        ready,
  output logic                        wordValid,
  output logic [23:0]                 wordData,
  afwcr_if.host                       lnk
);

  afwcr_pkg::afwcr_host_st_t st;
  afwcr_pkg::afwcr_mode_t    mode;
  logic [9:0]  timer;
  logic [8:0]  fallsLeft;
  logic        skip;
  logic [4:0]  bitInWord;
  logic [23:0] shiftIn;
  logic [15:0] wrShift;
  logic        sckReg, cnvReg, sdiReg;
  logic        sdoMeta, sdoSync;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic [4:0] wordLen  = statusOn ? 5'(`AFW_FULL_BITS) : 5'(`AFW_DATA_BITS);
  wire logic       isBusy   = (mode == afwcr_pkg::MODE_CS_BUSY);
  wire logic       isChain  = (mode == afwcr_pkg::MODE_CHAIN);
  wire logic [8:0] chainLen = 9'(wordLen * chainCount);
  wire logic [8:0] readLen  = isChain ? chainLen
                            : {4'h0, wordLen} + {8'h00, isBusy};
  wire logic       halfUp   = (timer == 10'(`AFW_HALF_SCK - 1));
  wire logic       fallNow  = halfUp & sckReg;
  wire logic       lastFall = fallNow & (fallsLeft == 9'h001);
  wire logic       wordEnd  = (bitInWord == wordLen - 5'h01);

  // ------------------------------------------------------------
  // data line synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sdoMeta <= 1'b1;
      sdoSync <= 1'b1;
    end else begin
      sdoMeta <= lnk.sdoLine;
      sdoSync <= sdoMeta;
    end
  end

  // ------------------------------------------------------------
  // frame sequencing; sck moves only in shift and write states
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st        <= afwcr_pkg::H_IDLE;
      mode      <= afwcr_pkg::MODE_CS_FREE;
      timer     <= 10'h000;
      fallsLeft <= 9'h000;
      skip      <= 1'b0;
      bitInWord <= 5'h00;
      shiftIn   <= 24'h00_0000;
      wrShift   <= 16'h0000;
      sckReg    <= 1'b0;
      cnvReg    <= 1'b0;
      sdiReg    <= 1'b1;
      wordValid <= 1'b0;
      wordData  <= 24'h00_0000;
    end else begin
      wordValid <= 1'b0;
      timer     <= timer + 10'h001;
      unique case (st)
        afwcr_pkg::H_IDLE: begin
          timer  <= 10'h000;
          sckReg <= 1'b0;
          if (startReq) begin
            mode   <= modeReq;
            sdiReg <= (modeReq != afwcr_pkg::MODE_CHAIN);
            st     <= afwcr_pkg::H_SETUP;
          end else if (writeReq) begin
            wrShift   <= {wrCmd[6:0], wrData, 1'b0};
            sdiReg    <= wrCmd[7];
            fallsLeft <= wrClocks;
            st        <= afwcr_pkg::H_WRITE;
          end
        end
        afwcr_pkg::H_SETUP: begin
          if (timer == 10'(`AFW_SETUP_CYC - 1)) begin
            cnvReg <= 1'b1;
            timer  <= 10'h000;
            st     <= afwcr_pkg::H_CONV;
          end
        end
        afwcr_pkg::H_CONV: begin
          if (isBusy) begin
            sdiReg <= 1'b0;
          end
          if (timer == 10'(`AFW_CONV_MAX_CYC - 1)) begin
            timer     <= 10'h000;
            fallsLeft <= readLen;
            skip      <= isBusy;
            bitInWord <= 5'h00;
            if (!isChain) begin
              sdiReg <= 1'b0;
            end
            st <= isBusy ? afwcr_pkg::H_WAIT : afwcr_pkg::H_SHIFT;
          end
        end
        afwcr_pkg::H_WAIT: begin
          timer <= 10'h000;
          if (!sdoSync) begin
            st <= afwcr_pkg::H_SHIFT;
          end
        end
        afwcr_pkg::H_SHIFT: begin
          if (halfUp) begin
            timer  <= 10'h000;
            sckReg <= ~sckReg;
          end
          if (fallNow) begin
            fallsLeft <= fallsLeft - 9'h001;
            skip      <= 1'b0;
            if (!skip) begin
              shiftIn   <= {shiftIn[22:0], sdoSync};
              bitInWord <= wordEnd ? 5'h00 : bitInWord + 5'h01;
              if (wordEnd) begin
                wordValid <= 1'b1;
                wordData  <= statusOn ? {shiftIn[22:0], sdoSync}
                                      : {shiftIn[16:0], sdoSync, 6'h00};
              end
            end
            if (lastFall) begin
              sdiReg <= 1'b1;
              timer  <= 10'h000;
              st     <= afwcr_pkg::H_DONE;
            end
          end
        end
        afwcr_pkg::H_DONE: begin
          if (halfUp) begin
            cnvReg <= 1'b0;
            st     <= afwcr_pkg::H_IDLE;
          end
        end
        afwcr_pkg::H_WRITE: begin
          if (halfUp) begin
            timer  <= 10'h000;
            sckReg <= ~sckReg;
          end
          if (fallNow) begin
            fallsLeft <= fallsLeft - 9'h001;
            sdiReg    <= wrShift[15];
            wrShift   <= {wrShift[14:0], 1'b0};
            if (lastFall) begin
              sdiReg <= 1'b1;
              st     <= afwcr_pkg::H_IDLE;
            end
          end
        end
        default: begin
          st <= afwcr_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign ready         = (st == afwcr_pkg::H_IDLE);
  assign lnk.sck       = sckReg;
  assign lnk.convStart = cnvReg;
  assign lnk.sdi       = sdiReg;

endmodule // afwcr_host

/* afwcr_link_properties.sv */
// concurrent checks on the converter link signals
module afwcr_link_properties (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic convStart,
  input wire logic sdi,
  input wire logic sdoOut,
  input wire logic sdoOe,
  input wire logic sdoLine
);
  logic       cnvQ;
  logic       chainSeen;
  logic [6:0] convAge;

  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  // cycles since convert rise, mode picked at that rise
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnvQ      <= 1'b0;
      chainSeen <= 1'b0;
      convAge   <= 7'h00;
    end else begin
      cnvQ <= convStart;
      if (convStart && !cnvQ) begin
        chainSeen <= !sck && !sdi;
        convAge   <= 7'h01;
      end else if (convAge != 7'h00 && convAge != 7'h7F) begin
        convAge <= convAge + 7'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // both selects low long enough to pass the synchronisers
  sequence low_run_s;
    (!sdi && !convStart) [*4];
  endsequence
  // bit unchanged from rising sck until the next fall
  sequence bit_hold_s;
    ##1 $stable(sdoOut) [*3];
  endsequence
  // line pulled low by the end-of-conversion flag
  sequence busy_flag_s;
    ##[1:10] (sdoOe && !sdoLine);
  endsequence

  AST_CONV_QUIET: assert property (convAge > 7'h04 && convAge < 7'h38 |-> !sdoOe)
    else $error("sdo driven during conversion");
  AST_LOW_DRIVE: assert property (low_run_s |-> sdoOe)
    else $error("sdo released with sdi and convert low");
  AST_SELECT_MSB: assert property ($fell(sdi) && convStart && !chainSeen && convAge > 7'h3E
    |-> ##[1:5] sdoOe)
    else $error("sdo not driven after select");
  AST_BIT_HOLD: assert property (sdoOe && convStart && $rose(sck) |-> bit_hold_s)
    else $error("sdo bit moved between sck edges");
  AST_SDI_RISE_OFF: assert property ($rose(sdi) && convStart && !chainSeen
    |-> ##[1:5] !sdoOe)
    else $error("sdo not released after sdi rise");
  AST_BUSY_FLAG: assert property (convStart && !chainSeen && !sdi && convAge == 7'h38
    |-> busy_flag_s)
    else $error("busy flag missing at conversion end");
  AST_SCK_QUIET: assert property (convAge > 7'h01 && convAge < 7'h38 |-> $stable(sck))
    else $error("sck moved during conversion");
  AST_CNV_HELD: assert property (convAge > 7'h00 && convAge < 7'h38 |-> convStart)
    else $error("convert start dropped during conversion");
endmodule // afwcr_link_properties

/* testbench.sv */
// self-checking bench joining host and converter ends over the link
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                   core_clk;
  logic                   resetn;
  logic [17:0]            sampleData;
  logic [5:0]             statusBits;
  logic                   statusOn;
  logic                   convDone;
  logic                   regValid;
  logic [7:0]             regCmd;
  logic [7:0]             regData;
  logic                   chainMode;
  logic                   startReq;
  afwcr_pkg::afwcr_mode_t modeReq;
  logic [3:0]             chainCount;
  logic                   writeReq;
  logic [7:0]             wrCmd;
  logic [7:0]             wrData;
  logic [8:0]             wrClocks;
  logic                   ready;
  logic                   wordValid;
  logic [23:0]            wordData;
  logic [31:0]            oeFalls = 32'h0000_0000;
  logic [31:0]            regHits = 32'h0000_0000;
  logic [31:0]            convHits = 32'h0000_0000;
  logic                   sckPrev = 1'b0;
  logic                   cnvPrev = 1'b0;
  int                     num_errors = 0;
  int                     comparisons = 0;

  afwcr_if linkBus ();

  afwcr_device afwcr_device_inst (.core_clk(core_clk), .resetn(resetn),
    .sampleData(sampleData), .statusBits(statusBits), .statusOn(statusOn),
    .convDone(convDone), .regValid(regValid), .regCmd(regCmd), .regData(regData),
    .chainMode(chainMode), .lnk(linkBus));

  afwcr_host afwcr_host_inst (.core_clk(core_clk), .resetn(resetn), .startReq(startReq),
    .modeReq(modeReq), .statusOn(statusOn), .chainCount(chainCount), .writeReq(writeReq),
    .wrCmd(wrCmd), .wrData(wrData), .wrClocks(wrClocks), .ready(ready),
    .wordValid(wordValid), .wordData(wordData), .lnk(linkBus));

  afwcr_link_properties afwcr_link_properties_inst (.core_clk(core_clk), .resetn(resetn),
    .sck(linkBus.sck), .convStart(linkBus.convStart), .sdi(linkBus.sdi),
    .sdoOut(linkBus.sdoOut), .sdoOe(linkBus.sdoOe), .sdoLine(linkBus.sdoLine));

  // 200 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // counts sck falls that leave sdo driven, plus pulses
  always @(posedge core_clk) begin
    if (linkBus.convStart && !cnvPrev) begin
      oeFalls <= 32'h0000_0000;
    end else if (sckPrev && !linkBus.sck && linkBus.sdoOe) begin
      oeFalls <= oeFalls + 32'h0000_0001;
    end
    sckPrev <= linkBus.sck;
    cnvPrev <= linkBus.convStart;
    if (regValid === 1'b1) begin
      regHits <= regHits + 32'h0000_0001;
    end
    if (convDone === 1'b1) begin
      convHits <= convHits + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 600) begin
      step();
      n++;
    end
    if (n >= 600) begin
      check("ready wait", 32'h0000_0000, 32'h0000_0001);
      wrap_up();
    end
  endtask

  // one conversion and readout, waits for the word
  task automatic do_read(input afwcr_pkg::afwcr_mode_t m, input logic st,
                         input logic [17:0] smp);
    int          n;
    logic [31:0] hits;
    n = 0;
    wait_ready();
    hits = convHits;
    modeReq = m;
    statusOn = st;
    sampleData = smp;
    startReq = 1'b1;
    step();
    startReq = 1'b0;
    while (wordValid !== 1'b1 && n < 2000) begin
      step();
      n++;
    end
    if (n >= 2000) begin
      check("word wait", 32'h0000_0000, 32'h0000_0001);
      wrap_up();
    end
    check("conversion pulses", convHits, hits + 32'h0000_0001);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_cs_free();
    do_read(afwcr_pkg::MODE_CS_FREE, 1'b0, 18'h2_5A3C);
    check("free word", {8'h00, wordData}, {8'h00, 18'h2_5A3C, 6'h00});
    check("free driven falls", oeFalls, 32'h0000_0011);
    check("free chain mode", {31'h0, chainMode}, 32'h0000_0000);
    $display("test_cs_free done");
  endtask

  task automatic test_cs_busy();
    do_read(afwcr_pkg::MODE_CS_BUSY, 1'b0, 18'h1_C3A5);
    check("busy word", {8'h00, wordData}, {8'h00, 18'h1_C3A5, 6'h00});
    do_read(afwcr_pkg::MODE_CS_BUSY, 1'b1, 18'h0_0001);
    check("busy status word", {8'h00, wordData}, {8'h00, 18'h0_0001, 6'h2D});
    $display("test_cs_busy done");
  endtask

  task automatic test_status();
    do_read(afwcr_pkg::MODE_CS_FREE, 1'b1, 18'h3_FFFE);
    check("status word", {8'h00, wordData}, {8'h00, 18'h3_FFFE, 6'h2D});
    check("status driven falls", oeFalls, 32'h0000_0017);
    $display("test_status done");
  endtask

  task automatic test_chain();
    do_read(afwcr_pkg::MODE_CHAIN, 1'b0, 18'h3_0F0F);
    check("chain word", {8'h00, wordData}, {8'h00, 18'h3_0F0F, 6'h00});
    check("chain mode", {31'h0, chainMode}, 32'h0000_0001);
    do_read(afwcr_pkg::MODE_CHAIN, 1'b1, 18'h0_A5A5);
    check("chain status word", {8'h00, wordData}, {8'h00, 18'h0_A5A5, 6'h2D});
    $display("test_chain done");
  endtask

  // register writes along a one-converter chain, taken at next start
  task automatic test_chain_write();
    logic [15:0] pat [2];
    logic [31:0] hits;
    pat[0] = 16'hA53C;
    pat[1] = 16'h5AC3;
    for (int i = 0; i < 2; i++) begin
      wait_ready();
      hits = regHits;
      wrCmd = pat[i][15:8];
      wrData = pat[i][7:0];
      wrClocks = 9'h010;
      writeReq = 1'b1;
      step();
      writeReq = 1'b0;
      do_read(afwcr_pkg::MODE_CHAIN, 1'b0, 18'h2_4681);
      check("write pulses", regHits, hits + 32'h0000_0001);
      check("write command", {24'h0, regCmd}, {24'h0, pat[i][15:8]});
      check("write data", {24'h0, regData}, {24'h0, pat[i][7:0]});
    end
    $display("test_chain_write done");
  endtask

  task automatic test_back_to_cs();
    do_read(afwcr_pkg::MODE_CS_FREE, 1'b0, 18'h1_2345);
    check("return word", {8'h00, wordData}, {8'h00, 18'h1_2345, 6'h00});
    check("return mode", {31'h0, chainMode}, 32'h0000_0000);
    $display("test_back_to_cs done");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    startReq = 1'b0;
    modeReq = afwcr_pkg::MODE_CS_FREE;
    statusOn = 1'b0;
    chainCount = 4'h1;
    writeReq = 1'b0;
    wrCmd = 8'h00;
    wrData = 8'h00;
    wrClocks = 9'h000;
    sampleData = 18'h0_0000;
    statusBits = 6'h2D;
    repeat (20) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    repeat (4) step();
    test_cs_free();
    test_cs_busy();
    test_status();
    test_chain();
    test_chain_write();
    test_back_to_cs();
    wrap_up();
  end
endmodule // testbench
